// file: hw/ism_pkg.sv
// Package with constants for the indicator status monitor
package ism_pkg;
	localparam int NUM_IND = 5;
	localparam int NUM_SIG = 4;
	localparam int CODE_W = 2;
	localparam int STAMP_W = 32;
	localparam int EVT_ID_W = 3;
	localparam int EVT_SIG_W = 2;
	// Status codes as displayed
	localparam logic [1:0] ST_INTERMEDIATE = 2'h0;
	localparam logic [1:0] ST_OPEN = 2'h1;
	localparam logic [1:0] ST_CLOSED = 2'h2;
	localparam logic [1:0] ST_BAD = 2'h3;
	localparam logic [1:0] ST_RESET = ST_OPEN;
	// Event mask selection
	localparam logic [1:0] MASK_NONE = 2'h0;
	localparam logic [1:0] MASK_ON = 2'h1;
	localparam logic [1:0] MASK_OFF = 2'h2;
	localparam logic [1:0] MASK_BOTH = 2'h3;
	// Timebase: 1 ms tick from the 20 MHz clock
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int TICK_W = 15;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [TICK_W-1:0] TICK_ZERO = 15'h0000;
	localparam logic [STAMP_W-1:0] STAMP_ZERO = 32'h0000_0000;
	localparam logic [STAMP_W-1:0] STAMP_ONE = 32'h0000_0001;
	localparam int SYNC_STAGES = 3;
endpackage

// file: hw/ism_channel.sv
// One indicator channel: input synchroniser and status decode
`timescale 1ns/1ps
module ism_channel (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Raw status inputs
	input wire logic open_in,
	input wire logic close_in,
	// Timebase
	input wire logic tick,
	// Decoded status
	output logic [1:0] status
);
	logic [2:0] open_sync_ff;
	logic [2:0] close_sync_ff;
	logic open_ff;
	logic close_ff;
	logic [1:0] status_ff;
	logic [1:0] nxt_status;
	wire open_agree = open_sync_ff[1] == open_sync_ff[2];
	wire close_agree = close_sync_ff[1] == close_sync_ff[2];

	// Three stages; a change counts when stages two and three agree
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			open_sync_ff <= 3'h0;
			close_sync_ff <= 3'h0;
		end else begin
			open_sync_ff <= {open_sync_ff[1:0], open_in};
			close_sync_ff <= {close_sync_ff[1:0], close_in};
		end
	end

	// Filtered levels; reset state matches the Open code
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			open_ff <= 1'b1;
			close_ff <= 1'b0;
		end else begin
			if (open_agree)
				open_ff <= open_sync_ff[2];
			if (close_agree)
				close_ff <= close_sync_ff[2];
		end
	end

	// Open is a logic one on the open input and zero on the close input
	assign nxt_status = (!open_ff && !close_ff) ? ism_pkg::ST_INTERMEDIATE :
		(open_ff && close_ff) ? ism_pkg::ST_BAD :
		open_ff ? ism_pkg::ST_OPEN : ism_pkg::ST_CLOSED;

	// Re-evaluated once per timebase tick
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			status_ff <= ism_pkg::ST_RESET;
		else if (tick)
			status_ff <= nxt_status;
	end

	assign status = status_ff;
endmodule

// file: hw/ism_monitor.sv
// Top of the indicator status monitor: five channels, timebase and event output
`timescale 1ns/1ps
module ism_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Status inputs, one bit per indicator (close fed inverted by the outside for one-input use)
	input wire logic [4:0] open_in,
	input wire logic [4:0] close_in,
	// Setup, static during operation
	input wire logic [1:0] event_mask,
	// Decoded status, two bits per indicator
	output logic [9:0] status,
	// Event stream
	output logic event_valid,
	input wire logic event_ready,
	output logic [2:0] event_indicator,
	output logic [1:0] event_signal,
	output logic event_on,
	output logic [31:0] event_stamp,
	// Events lost for lack of a ready sink
	output logic event_overrun
);
	localparam int PEND_W = ism_pkg::NUM_IND * ism_pkg::NUM_SIG;

	////////////////////////////////////////////////////////////////////////////
	logic [ism_pkg::TICK_W-1:0] tick_cnt_ff;
	logic [ism_pkg::STAMP_W-1:0] stamp_ff;
	wire tick = tick_cnt_ff == ism_pkg::TICK_LAST;

	// Millisecond timebase and stamp
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			tick_cnt_ff <= ism_pkg::TICK_ZERO;
			stamp_ff <= ism_pkg::STAMP_ZERO;
		end else if (tick) begin
			tick_cnt_ff <= ism_pkg::TICK_ZERO;
			stamp_ff <= stamp_ff + ism_pkg::STAMP_ONE;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 15'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Five independent channels
	logic [1:0] st [ism_pkg::NUM_IND];
	logic [1:0] st_prev_ff [ism_pkg::NUM_IND];
	logic [PEND_W-1:0] onehot_now;
	logic [PEND_W-1:0] onehot_prev;

	for (genvar i = 0; i < ism_pkg::NUM_IND; i++) begin : g_ch
		ism_channel u_ch (
			.clock(clock),
			.reset(reset),
			.open_in(open_in[i]),
			.close_in(close_in[i]),
			.tick(tick),
			.status(st[i])
		);
		assign status[2*i +: 2] = st[i];
		// Each status code is one of four signals; the level of each is its one-hot bit
		for (genvar s = 0; s < ism_pkg::NUM_SIG; s++) begin : g_sig
			assign onehot_now[i*ism_pkg::NUM_SIG + s] = st[i] == 2'(s);
			assign onehot_prev[i*ism_pkg::NUM_SIG + s] = st_prev_ff[i] == 2'(s);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < ism_pkg::NUM_IND; i++)
				st_prev_ff[i] <= ism_pkg::ST_RESET;
		end else begin
			for (int i = 0; i < ism_pkg::NUM_IND; i++)
				st_prev_ff[i] <= st[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pending event flags; rising level gives ON, falling gives OFF
	wire mask_on = event_mask[0];
	wire mask_off = event_mask[1];
	wire [PEND_W-1:0] rise = onehot_now & ~onehot_prev;
	wire [PEND_W-1:0] fall = ~onehot_now & onehot_prev;
	wire [PEND_W-1:0] new_on = rise & {PEND_W{mask_on}};
	wire [PEND_W-1:0] new_off = fall & {PEND_W{mask_off}};

	logic [PEND_W-1:0] pend_on_ff;
	logic [PEND_W-1:0] pend_off_ff;
	logic [ism_pkg::STAMP_W-1:0] pend_stamp_ff [PEND_W];

	// Lowest pending index wins; ON before OFF for the same signal
	logic sel_found;
	logic sel_is_on;
	logic [4:0] sel_idx;
	always_comb begin
		sel_found = 1'b0;
		sel_is_on = 1'b0;
		sel_idx = 5'h00;
		for (int k = 0; k < PEND_W; k++) begin
			if (!sel_found && (pend_on_ff[k] || pend_off_ff[k])) begin
				sel_found = 1'b1;
				sel_is_on = pend_on_ff[k];
				sel_idx = 5'(k);
			end
		end
	end

	logic out_valid_ff;
	wire out_free = !out_valid_ff || event_ready;
	wire take = sel_found && out_free;
	wire [PEND_W-1:0] take_vec = take ? (PEND_W'(1) << sel_idx) : '0;
	wire [PEND_W-1:0] clr_on = take_vec & {PEND_W{sel_is_on}};
	wire [PEND_W-1:0] clr_off = take_vec & {PEND_W{!sel_is_on}};
	// A new event that finds its flag still pending overwrites it and is counted lost
	wire lost = |((new_on & pend_on_ff & ~clr_on) | (new_off & pend_off_ff & ~clr_off));

	// Set wins over clear; events queued in the cycle after the tick that changes the status
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pend_on_ff <= '0;
			pend_off_ff <= '0;
		end else begin
			pend_on_ff <= (pend_on_ff & ~clr_on) | new_on;
			pend_off_ff <= (pend_off_ff & ~clr_off) | new_off;
		end
	end

	// Stamp taken when the event is queued, not when it leaves
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			for (int k = 0; k < PEND_W; k++)
				pend_stamp_ff[k] <= ism_pkg::STAMP_ZERO;
		end else begin
			for (int k = 0; k < PEND_W; k++)
				if (new_on[k] || new_off[k])
					pend_stamp_ff[k] <= stamp_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output register; no command outputs exist at all
	logic [2:0] ev_ind_ff;
	logic [1:0] ev_sig_ff;
	logic ev_on_ff;
	logic [31:0] ev_stamp_ff;
	logic overrun_ff;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			out_valid_ff <= 1'b0;
			ev_ind_ff <= 3'h0;
			ev_sig_ff <= 2'h0;
			ev_on_ff <= 1'b0;
			ev_stamp_ff <= ism_pkg::STAMP_ZERO;
		end else if (out_free) begin
			out_valid_ff <= sel_found;
			if (sel_found) begin
				ev_ind_ff <= 3'(sel_idx / 5'(ism_pkg::NUM_SIG));
				ev_sig_ff <= sel_idx[1:0];
				ev_on_ff <= sel_is_on;
				ev_stamp_ff <= pend_stamp_ff[sel_idx];
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			overrun_ff <= 1'b0;
		else
			overrun_ff <= lost;
	end

	assign event_valid = out_valid_ff;
	assign event_indicator = ev_ind_ff;
	assign event_signal = ev_sig_ff;
	assign event_on = ev_on_ff;
	assign event_stamp = ev_stamp_ff;
	assign event_overrun = overrun_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_inter_decode: assert property (@(posedge clock) disable iff (reset)
		tick && !open_in[0] && !close_in[0] && $past(!open_in[0] && !close_in[0], 4)
		&& $past(!open_in[0] && !close_in[0], 5)
		|=> status[1:0] == ism_pkg::ST_INTERMEDIATE)
		else $error("indicator 0 not intermediate with no inputs");
	chk_bad_decode: assert property (@(posedge clock) disable iff (reset)
		tick && $past(open_in[0] && close_in[0], 4) && $past(open_in[0] && close_in[0], 5)
		|=> status[1:0] == ism_pkg::ST_BAD)
		else $error("indicator 0 not bad with both inputs");
	chk_open_decode: assert property (@(posedge clock) disable iff (reset)
		tick && $past(open_in[1] && !close_in[1], 4) && $past(open_in[1] && !close_in[1], 5)
		|=> status[3:2] == ism_pkg::ST_OPEN)
		else $error("indicator 1 not open");
	chk_close_decode: assert property (@(posedge clock) disable iff (reset)
		tick && $past(!open_in[1] && close_in[1], 4) && $past(!open_in[1] && close_in[1], 5)
		|=> status[3:2] == ism_pkg::ST_CLOSED)
		else $error("indicator 1 not closed");
	chk_status_tick: assert property (@(posedge clock) disable iff (reset)
		!$past(tick) |-> $stable(status))
		else $error("status changed off tick");
	// One cycle after the change the previous-status copy holds the new code
	chk_change_queued: assert property (@(posedge clock) disable iff (reset)
		mask_on && (status[1:0] != st_prev_ff[0]) |=> pend_on_ff[st_prev_ff[0]])
		else $error("change not queued");
	chk_mask_drop: assert property (@(posedge clock) disable iff (reset)
		event_valid && event_on |-> mask_on)
		else $error("ON event passed with ON masked");
	chk_mask_off: assert property (@(posedge clock) disable iff (reset)
		event_valid && !event_on |-> mask_off)
		else $error("OFF event passed with OFF masked");
	chk_out_hold: assert property (@(posedge clock) disable iff (reset)
		event_valid && !event_ready |=> event_valid && $stable(event_stamp)
		&& $stable(event_indicator) && $stable(event_signal)
		&& $stable(event_on))
		else $error("event dropped under back-pressure");
endmodule

// file: dv/ism_contacts.sv
// Partner model: auxiliary contacts that feed the status inputs
`timescale 1ns/1ps
module ism_contacts (
	// Clock
	input wire logic clock,
	// Commanded contact positions
	input wire logic [4:0] pos_open,
	input wire logic [4:0] pos_close,
	input wire logic [4:0] single,
	// Contact levels toward the monitor
	output logic [4:0] open_in,
	output logic [4:0] close_in
);
	// One-input objects get close from the inverse of open
	always @(posedge clock) begin
		open_in <= pos_open;
		close_in <= (single & ~pos_open) | (~single & pos_close);
	end
endmodule

// file: dv/tb.sv
// Self-checking bench for the indicator status monitor
`timescale 1ns/1ps
module tb;
	logic clock, reset, event_ready, event_valid, event_on, event_overrun;
	logic [4:0] pos_open, pos_close, single, open_in, close_in;
	logic [1:0] event_mask, event_signal;
	logic [9:0] status;
	logic [2:0] event_indicator;
	logic [31:0] event_stamp;
	logic [5:0] got[$];
	logic [5:0] exp_q[$];
	logic [31:0] stamps[$];
	int error_cnt, checks, seed;
	// Overruns are counted over the whole run and must stay at zero
	int ovr = 0;

	ism_contacts u_ism_contacts (.clock(clock), .pos_open(pos_open), .pos_close(pos_close),
		.single(single), .open_in(open_in), .close_in(close_in));
	ism_monitor u_ism_monitor (.clock(clock), .reset(reset), .open_in(open_in),
		.close_in(close_in), .event_mask(event_mask), .status(status),
		.event_valid(event_valid), .event_ready(event_ready),
		.event_indicator(event_indicator), .event_signal(event_signal),
		.event_on(event_on), .event_stamp(event_stamp), .event_overrun(event_overrun));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sink stalls at random so events must wait while valid
	always @(posedge clock) begin
		event_ready <= ($random(seed) & 3) != 0;
		if (event_valid === 1'b1 && event_ready === 1'b1) begin
			got.push_back({event_indicator, event_signal, event_on});
			stamps.push_back(event_stamp);
		end
		if (event_overrun !== 1'b0 && reset === 1'b0)
			ovr++;
	end

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic results;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// One reset, one random contact pattern, one timebase tick
	task automatic phase(input logic [1:0] mask);
		int i, k, o, c, nc;
		logic [4:0] o5, c5, s5;
		logic [9:0] exp_st;
		@(posedge clock);
		reset <= 1'b1;
		event_mask <= mask;
		pos_open <= 5'h1f;
		pos_close <= 5'h00;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		check(32'(status), {22'h00_0000, {5{ism_pkg::ST_RESET}}});
		o5 = 5'($random(seed));
		c5 = 5'($random(seed));
		s5 = 5'($random(seed));
		// Indicator 0 goes Bad or Intermediate so every phase has a change
		o5[0] = mask[0];
		c5[0] = mask[0];
		s5[0] = 1'b0;
		// Indicator 1 alternates Open and Closed; its one-input choice stays random
		o5[1] = mask[1];
		c5[1] = !mask[1];
		pos_open <= o5;
		pos_close <= c5;
		single <= s5;
		got.delete();
		stamps.delete();
		exp_q.delete();
		for (i = 0; i < 5; i++) begin
			o = o5[i];
			c = s5[i] ? !o5[i] : c5[i];
			nc = (o && c) ? 3 : o ? 1 : c ? 2 : 0;
			exp_st[2*i +: 2] = 2'(nc);
			for (k = 0; k < 4; k++) begin
				if (nc != 1 && k == 1 && mask[1])
					exp_q.push_back(6'(i * 8 + 2));
				if (nc != 1 && k == nc && mask[0])
					exp_q.push_back(6'(i * 8 + k * 2 + 1));
			end
		end
		k = 0;
		while (status === {5{ism_pkg::ST_RESET}} && k < 21000) begin
			@(negedge clock);
			k++;
		end
		check(32'(status), 32'(exp_st));
		repeat (80) @(negedge clock);
		check(got.size(), exp_q.size());
		// The change is decoded on the first tick after reset, so every event is stamped 1 ms
		for (i = 0; i < exp_q.size() && i < got.size(); i++) begin
			check(32'(got[i]), 32'(exp_q[i]));
			check(stamps[i], 32'h0000_0001);
		end
		check(ovr, 0);
	endtask

	initial begin
		seed = 32'h8695_9a26;
		reset = 1'b1;
		event_mask = ism_pkg::MASK_BOTH;
		pos_open = 5'h1f;
		pos_close = 5'h00;
		single = 5'h00;
		error_cnt = 0;
		checks = 0;
		// Mask is setup only, so it changes while reset holds the block
		phase(ism_pkg::MASK_BOTH);
		phase(ism_pkg::MASK_ON);
		phase(ism_pkg::MASK_OFF);
		phase(ism_pkg::MASK_NONE);
		results();
	end

	// Four phases take about 80300 cycles
	initial begin
		repeat (95000) @(posedge clock);
		error_cnt++;
		results();
	end
endmodule
